// [inc/cmp_pkg.sv]
// Shared constants and types for the comparator output and change-flag control block.
// Assumes a single clock domain and an AHB-Lite register bus with 32-bit data.
package cmp_pkg;

   // Number of comparators and comparator-related port pins.
   localparam int unsigned CMP_NUM  = 2;
   localparam int unsigned PIN_NUM  = 6;

   // Register byte offsets on the bus.
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_FLAG   = 8'h04;
   localparam logic [7:0] OFS_ENABLE = 8'h08;
   localparam logic [7:0] OFS_IRQCTL = 8'h0C;
   localparam logic [7:0] OFS_PORT   = 8'h10;
   localparam logic [7:0] OFS_DIR    = 8'h14;

   // Field positions inside comparator_config_reg.
   localparam int unsigned CFG_MODE_LSB = 0;
   localparam int unsigned CFG_CIS_BIT  = 3;
   localparam int unsigned CFG_INV_LSB  = 4;
   localparam int unsigned CFG_OUT_LSB  = 6;

   // Field positions inside irq_control_reg.
   localparam int unsigned IRQ_PERIPH_BIT = 6;
   localparam int unsigned IRQ_GLOBAL_BIT = 7;

   // Pin indices of the comparator pins.
   localparam int unsigned PIN_C1_OUT = 2;
   localparam int unsigned PIN_C2_OUT = 5;

   // Values after reset.
   localparam logic [5:0] RST_PORT = 6'h00;
   localparam logic [5:0] RST_DIR  = 6'h3F;

   // Four-phase instruction clock derived from hclk.
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [1:0] PHASE_Q1   = 2'h0;

   // Comparator operating modes, named after the dual variant.
   typedef enum logic [2:0] {
      MODE_RESET     = 3'b000,
      MODE_MUX3      = 3'b001,
      MODE_MUX4      = 3'b010,
      MODE_COMREF    = 3'b011,
      MODE_INDEP2    = 3'b100,
      MODE_INDEP1    = 3'b101,
      MODE_COMREF_DO = 3'b110,
      MODE_OFF       = 3'b111
   } cmp_mode_t;

   // Software-written part of comparator_config_reg.
   typedef struct packed {
      logic [1:0] inv;
      logic       input_switch_select;
      cmp_mode_t  mode;
   } cmp_cfg_t;

   // Pin role masks: analog input or comparator-driven digital output.
   typedef struct packed {
      logic [5:0] analog;
      logic [5:0] digital;
   } cmp_pinmap_t;

endpackage

// [verilog/cmp_mismatch.sv]
// Change detector for one comparator: reference latch, phase sample latch and sticky flag.
// Assumes ref_load and flag writes come from the bus slave in the same hclk domain.
`timescale 1ns/1ps
module cmp_mismatch
   import cmp_pkg::*;
(
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Control
   input  wire logic q1,
   input  wire logic result,
   input  wire logic ref_load,
   input  wire logic flag_wr,
   input  wire logic flag_wr_val,
   // Status
   output logic      mismatch,
   output logic      flag
);

   logic ref_r;
   logic sample_r;
   logic flag_r;
   logic flag_nxt;

   // Mismatch is the difference of the two latches.
   // exclusive-or detect
   assign mismatch = ref_r ^ sample_r;
   assign flag     = flag_r;

   // A live mismatch wins over a software clear; a write of one sets the flag.
   // software flag write
   assign flag_nxt = mismatch | (flag_wr ? flag_wr_val : flag_r);

   // Reference latch follows the output on each configuration access.
   // reference capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_r <= 1'b0;
      end else if (ref_load) begin
         ref_r <= result;
      end
   end

   // Sample latch follows the output only on the first clock phase.
   // phase sample
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sample_r <= 1'b0;
      end else if (q1) begin
         sample_r <= result;
      end
   end

   // Sticky change flag, held while the mismatch lasts.
   // mismatch holds flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   chk_flag_hold: assert property (@(posedge hclk) disable iff (!hresetn) mismatch |=> flag_r)
      else $error("change flag not set during mismatch");

   chk_ref_capture: assert property (@(posedge hclk) disable iff (!hresetn) ref_load |=> ref_r == $past(result))
      else $error("reference latch missed configuration access");

   chk_sample_phase: assert property (@(posedge hclk) disable iff (!hresetn) !q1 |=> $stable(sample_r))
      else $error("sample latch moved outside first phase");

   chk_clear_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
      (mismatch && flag_wr && !flag_wr_val) |=> flag_r)
      else $error("flag cleared while mismatch persists");

endmodule

// [verilog/cmp_ctrl.sv]
// Comparator control top: configuration, pin roles, change flags and interrupt request.
// Assumes the analog comparators deliver their raw results as synchronous inputs.
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps

// Behaviour
// - Raw result high when noninverting input higher
// - Invert bit complements reported and driven output
// - Three-bit mode selects one of eight setups
// - Analog, digital or normal role per pin
// - Analog pins read zero from the port
// - Result bits always readable in configuration register
// - Output pin driven only in routing modes
// - Switch bit picks inverting input, both analog
// - Flag set when output differs from captured
// - Second latch samples on first phase; XOR
// - Mismatch keeps flag set until resolved
// - Configuration write also refreshes the reference
// - Write zero clears flag, one sets it
// - Request needs change, peripheral, global enables
// - Clear ignored while mismatch persists
// - Change during read may miss the flag
// - Reset returns mode zero, pins analog
module cmp_ctrl
   import cmp_pkg::*;
#(
   parameter bit DUAL_VARIANT = 1'b1
)
(
   // Clock and reset
   input  wire logic                hclk,
   input  wire logic                hresetn,
   // AHB-Lite slave
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   // Analog comparator side
   input  wire logic [CMP_NUM-1:0]  cmp_raw,
   output logic      [CMP_NUM-1:0]  cmp_enable,
   output logic      [CMP_NUM-1:0]  cmp_inm_sel,
   // Port pins
   input  wire logic [PIN_NUM-1:0]  pin_in,
   output logic      [PIN_NUM-1:0]  pin_out,
   output logic      [PIN_NUM-1:0]  pin_oe,
   output logic      [PIN_NUM-1:0]  pin_ain,
   // Interrupt request
   output logic                     comparator_irq_req
);

   // Pin roles for each mode and variant.
   function automatic cmp_pinmap_t pin_roles(input logic dual, input logic [2:0] mode);
      cmp_pinmap_t m;
      m = '0;
      if (dual) begin
         unique case (mode)
            3'b000, 3'b001, 3'b010, 3'b100: m.analog = 6'h1B;
            3'b011: m.analog = 6'h19;
            3'b101: m.analog = 6'h18;
            3'b110: begin
               m.analog  = 6'h19;
               m.digital = 6'h24;
            end
            3'b111: m = '0;
         endcase
      end else begin
         unique case (mode)
            3'b000, 3'b010, 3'b110: m.analog = 6'h03;
            3'b001, 3'b101: begin
               m.analog  = 6'h03;
               m.digital = 6'h04;
            end
            3'b011: begin
               m.analog  = 6'h01;
               m.digital = 6'h04;
            end
            3'b100: m.analog = 6'h01;
            3'b111: m = '0;
         endcase
      end
      return m;
   endfunction

   // Address match on the low byte of a bus address.
   function automatic logic addr_is(input logic [31:0] a, input logic [7:0] ofs);
      return (a[7:0] == ofs);
   endfunction

   logic [1:0]          phase_r;
   cmp_cfg_t            cfg_r;
   logic [CMP_NUM-1:0]  chg_en_r;
   logic                gie_r;
   logic                peripheral_irq_enable_r;
   logic [PIN_NUM-1:0]  port_r;
   logic [PIN_NUM-1:0]  dir_r;
   logic                wr_pend_r;
   logic [31:0]         wr_addr_r;
   logic [31:0]         hrdata_r;
   logic [CMP_NUM-1:0]  cmp_enable_r;
   logic [CMP_NUM-1:0]  cmp_inm_sel_r;
   logic [PIN_NUM-1:0]  pin_out_r;
   logic [PIN_NUM-1:0]  pin_oe_r;
   logic [PIN_NUM-1:0]  pin_ain_r;
   logic                irq_r;
   logic                hreadyout_r;
   logic                hresp_r;

   // Four-phase counter; phase zero is the first clock phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_r <= PHASE_Q1;
      end else begin
         phase_r <= (phase_r == PHASE_LAST) ? PHASE_Q1 : phase_r + 2'h1;
      end
   end

   wire q1 = (phase_r == PHASE_Q1);

   // Address phase decode; a transfer is taken when selected, ready and non-idle.
   wire ap_take   = hsel & hready & htrans[1];
   wire ap_rd     = ap_take & ~hwrite;
   wire ap_cfg    = ap_take & addr_is(haddr, OFS_CONFIG);
   wire dp_cfg    = wr_pend_r & addr_is(wr_addr_r, OFS_CONFIG);
   wire dp_flag   = wr_pend_r & addr_is(wr_addr_r, OFS_FLAG);
   wire dp_enable = wr_pend_r & addr_is(wr_addr_r, OFS_ENABLE);
   wire dp_irqctl = wr_pend_r & addr_is(wr_addr_r, OFS_IRQCTL);
   wire dp_port   = wr_pend_r & addr_is(wr_addr_r, OFS_PORT);
   wire dp_dir    = wr_pend_r & addr_is(wr_addr_r, OFS_DIR);

   // Mode-dependent decode of pin roles, comparator power and input switch.
   // mode decode
   wire cmp_pinmap_t pmap = pin_roles(DUAL_VARIANT, cfg_r.mode);
   wire mode_off          = (cfg_r.mode == MODE_RESET) | (cfg_r.mode == MODE_OFF);
   wire c1_on             = ~mode_off & ~(DUAL_VARIANT & (cfg_r.mode == MODE_INDEP1));
   wire c2_on             = DUAL_VARIANT & ~mode_off;
   wire [CMP_NUM-1:0] cmp_on_w = {c2_on, c1_on};
   wire sw1 = DUAL_VARIANT ? (cfg_r.mode == MODE_MUX3) | (cfg_r.mode == MODE_MUX4)
                           : (cfg_r.mode == MODE_INDEP1) | (cfg_r.mode == MODE_COMREF_DO);
   wire sw2 = DUAL_VARIANT & (cfg_r.mode == MODE_MUX4);
   wire [CMP_NUM-1:0] inm_sel_w = {sw2, sw1} & {CMP_NUM{cfg_r.input_switch_select}};

   // Comparator outputs: raw result, forced low when powered down, then polarity.
   // raw result taken
   wire [CMP_NUM-1:0] cmp_result = (cmp_raw & cmp_on_w) ^ cfg_r.inv;

   // Port read: pins in the analog role read as zero.
   // analog reads zero
   wire [PIN_NUM-1:0] port_rd = pin_in & ~pmap.analog;

   // Per-comparator change detectors.
   // write refreshes reference
   wire                ref_load = ap_cfg;
   wire [CMP_NUM-1:0]  flag_w;
   wire [CMP_NUM-1:0]  mismatch_w;

   for (genvar i = 0; i < CMP_NUM; i++) begin : g_det
      cmp_mismatch u_det (
         .hclk        (hclk),
         .hresetn     (hresetn),
         .q1          (q1),
         .result      (cmp_result[i]),
         .ref_load    (ref_load),
         .flag_wr     (dp_flag),
         .flag_wr_val (hwdata[i]),
         .mismatch    (mismatch_w[i]),
         .flag        (flag_w[i])
      );
   end

   // Read data selection.
   // result always readable
   wire [31:0] rd_mux =
      addr_is(haddr, OFS_CONFIG) ? {24'h00_0000, cmp_result, cfg_r} :
      addr_is(haddr, OFS_FLAG)   ? {30'h0000_0000, flag_w} :
      addr_is(haddr, OFS_ENABLE) ? {30'h0000_0000, chg_en_r} :
      addr_is(haddr, OFS_IRQCTL) ? {24'h00_0000, gie_r, peripheral_irq_enable_r, 6'h00} :
      addr_is(haddr, OFS_PORT)   ? {26'h000_0000, port_rd} :
      addr_is(haddr, OFS_DIR)    ? {26'h000_0000, dir_r} : 32'h0000_0000;

   // Address phase capture for writes and read data register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 32'h0000_0000;
         hrdata_r  <= 32'h0000_0000;
      end else begin
         wr_pend_r <= ap_take & hwrite;
         wr_addr_r <= ap_take ? haddr : wr_addr_r;
         hrdata_r  <= ap_rd ? rd_mux : hrdata_r;
      end
   end

   // Configuration register; reset puts the block in mode zero.
   // reset to mode zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_r <= '0;
      end else if (dp_cfg) begin
         cfg_r <= cmp_cfg_t'(hwdata[CFG_OUT_LSB-1:0]);
      end
   end

   // Change enables, interrupt control, port latch and direction bits.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chg_en_r <= '0;
         gie_r    <= 1'b0;
         peripheral_irq_enable_r   <= 1'b0;
         port_r   <= RST_PORT;
         dir_r    <= RST_DIR;
      end else begin
         chg_en_r <= dp_enable ? hwdata[CMP_NUM-1:0] : chg_en_r;
         gie_r    <= dp_irqctl ? hwdata[IRQ_GLOBAL_BIT] : gie_r;
         peripheral_irq_enable_r   <= dp_irqctl ? hwdata[IRQ_PERIPH_BIT] : peripheral_irq_enable_r;
         port_r   <= dp_port ? hwdata[PIN_NUM-1:0] : port_r;
         dir_r    <= dp_dir ? hwdata[PIN_NUM-1:0] : dir_r;
      end
   end

   // Pin drive: digital-role pins carry the comparator output over the port latch.
   // pin role drive
   wire [PIN_NUM-1:0] cmp_on_pin = {cmp_result[1], 2'b00, cmp_result[0], 2'b00};
   wire [PIN_NUM-1:0] pin_out_w  = (pmap.digital & cmp_on_pin) | (~pmap.digital & port_r);

   // Interrupt request needs flag, change enable, peripheral and global enables.
   // enable gating
   wire irq_w = gie_r & peripheral_irq_enable_r & |(flag_w & chg_en_r);

   // Output registers.
   // driver follows direction
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_enable_r  <= '0;
         cmp_inm_sel_r <= '0;
         pin_out_r     <= '0;
         pin_oe_r      <= '0;
         pin_ain_r     <= '1;
         irq_r         <= 1'b0;
         hreadyout_r   <= 1'b1;
         hresp_r       <= 1'b0;
      end else begin
         cmp_enable_r  <= cmp_on_w;
         cmp_inm_sel_r <= inm_sel_w;
         pin_out_r     <= pin_out_w;
         pin_oe_r      <= ~dir_r;
         pin_ain_r     <= pmap.analog;
         irq_r         <= irq_w;
         hreadyout_r   <= 1'b1;
         hresp_r       <= 1'b0;
      end
   end

   // Zero-wait-state slave, always OKAY.
   assign hrdata             = hrdata_r;
   assign hreadyout          = hreadyout_r;
   assign hresp              = hresp_r;
   assign cmp_enable         = cmp_enable_r;
   assign cmp_inm_sel        = cmp_inm_sel_r;
   assign pin_out            = pin_out_r;
   assign pin_oe             = pin_oe_r;
   assign pin_ain            = pin_ain_r;
   assign comparator_irq_req = irq_r;

   chk_result_read: assert property (@(posedge hclk) disable iff (!hresetn)
      (ap_rd && addr_is(haddr, OFS_CONFIG)) |=> hrdata_r[CFG_OUT_LSB +: CMP_NUM] == $past(cmp_result))
      else $error("configuration read lost comparator result");

   chk_invert_out: assert property (@(posedge hclk) disable iff (!hresetn)
      (cfg_r.inv[0] && cmp_on_w[0]) |-> (cmp_result[0] == !cmp_raw[0]))
      else $error("inverted output does not complement raw result");

   chk_port_analog: assert property (@(posedge hclk) disable iff (!hresetn)
      (ap_rd && addr_is(haddr, OFS_PORT)) |=> (hrdata_r[PIN_NUM-1:0] & $past(pmap.analog)) == 6'h00)
      else $error("analog pin read nonzero");

   chk_out_route: assert property (@(posedge hclk) disable iff (!hresetn)
      pmap.digital[PIN_C1_OUT] |=> pin_out[PIN_C1_OUT] == $past(cmp_result[0]))
      else $error("comparator output not routed to pin");

   chk_no_route: assert property (@(posedge hclk) disable iff (!hresetn)
      !pmap.digital[PIN_C2_OUT] |=> pin_out[PIN_C2_OUT] == $past(port_r[PIN_C2_OUT]))
      else $error("port pin disturbed by comparator");

   chk_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      (!gie_r || !peripheral_irq_enable_r || (chg_en_r & flag_w) == '0) |=> !comparator_irq_req)
      else $error("interrupt requested without all enables");

   chk_switch_analog: assert property (@(posedge hclk) disable iff (!hresetn)
      sw1 |-> (pmap.analog[0] && pmap.analog[1] && (!sw2 || (pmap.analog[3] && pmap.analog[4]))))
      else $error("switched input pin left digital");

   chk_mode_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      !dp_cfg |=> $stable(cfg_r))
      else $error("configuration changed without a write");

   chk_flag_c2: assert property (@(posedge hclk) disable iff (!hresetn)
      mismatch_w[1] |=> flag_w[1])
      else $error("second change flag not set during its mismatch");

   chk_irq_raise: assert property (@(posedge hclk) disable iff (!hresetn)
      (gie_r && peripheral_irq_enable_r && (chg_en_r & flag_w) != '0) |=> comparator_irq_req)
      else $error("interrupt not requested with all enables set");

   chk_flag_set_wr: assert property (@(posedge hclk) disable iff (!hresetn)
      (dp_flag && hwdata[0]) |=> flag_w[0])
      else $error("software write of one did not set the flag");

   chk_flag_clear_wr: assert property (@(posedge hclk) disable iff (!hresetn)
      (dp_flag && !hwdata[0] && !mismatch_w[0]) |=> !flag_w[0])
      else $error("software write of zero did not clear the flag");

   chk_off_power: assert property (@(posedge hclk) disable iff (!hresetn)
      mode_off |=> (cmp_enable == '0))
      else $error("comparator powered in an off mode");

   chk_dual_off: assert property (@(posedge hclk) disable iff (!hresetn)
      (DUAL_VARIANT && cfg_r.mode == MODE_INDEP1) |=> !cmp_enable[0])
      else $error("first comparator powered in single independent mode");

   chk_c2_route: assert property (@(posedge hclk) disable iff (!hresetn)
      pmap.digital[PIN_C2_OUT] |=> pin_out[PIN_C2_OUT] == $past(cmp_result[1]))
      else $error("second comparator output not routed to pin");

   chk_role_exclusive: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |-> ((pmap.analog & pmap.digital) == '0))
      else $error("pin both analog and comparator driven");

   chk_switch_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      !cfg_r.input_switch_select |=> (cmp_inm_sel == '0))
      else $error("input switch moved with switch bit clear");

endmodule

// [bench/cmp_analog_model.sv]
// Far-side model: the two analog comparators and the outside levels of the port pins.
// Assumes the testbench supplies the pin voltages and the levels seen on undriven pins.
`timescale 1ns/1ps
module cmp_analog_model
   import cmp_pkg::*;
(
   // Analog stimulus, per comparator: plus, minus, alternate minus
   input  wire logic [47:0]         volts,
   input  wire logic [PIN_NUM-1:0]  ext_level,
   // Design side
   input  wire logic [CMP_NUM-1:0]  cmp_inm_sel,
   input  wire logic [PIN_NUM-1:0]  pin_out,
   input  wire logic [PIN_NUM-1:0]  pin_oe,
   output logic      [CMP_NUM-1:0]  cmp_raw,
   output logic      [PIN_NUM-1:0]  pin_in
);
   // Switch picks inverting source, high only when plus is higher.
   always_comb begin
      for (int k = 0; k < CMP_NUM; k++) begin
         cmp_raw[k] = volts[24*k +: 8] > (cmp_inm_sel[k] ? volts[24*k+16 +: 8] : volts[24*k+8 +: 8]);
      end
   end
   // A driven pin shows the design's level, any other the outside world.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// [bench/testbench.sv]
// Self-checking bench for the comparator control block, driven over AHB-Lite.
// Assumes the dual variant and the far-side model cmp_analog_model.
`timescale 1ns/1ps
module testbench
   import cmp_pkg::*;
;
   logic        hclk      = 1'b0;
   logic        hresetn   = 1'b0;
   logic        hsel      = 1'b0;
   logic [31:0] haddr     = '0;
   logic [1:0]  htrans    = 2'b00;
   logic        hwrite    = 1'b0;
   logic [31:0] hwdata    = '0;
   logic [47:0] volts     = '0;
   logic [5:0]  ext_level = '0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        irq;
   logic [1:0]  cmp_raw;
   logic [1:0]  cmp_enable;
   logic [1:0]  cmp_inm_sel;
   logic [5:0]  pin_in;
   logic [5:0]  pin_out;
   logic [5:0]  pin_oe;
   logic [5:0]  pin_ain;
   logic [31:0] rd;
   int          err_total = 0;
   int          cmp_count = 0;

   // Clock of 25 ns.
   always #12.5 hclk = ~hclk;

   cmp_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cmp_raw(cmp_raw), .cmp_enable(cmp_enable),
      .cmp_inm_sel(cmp_inm_sel), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_ain(pin_ain), .comparator_irq_req(irq));

   cmp_analog_model far (.volts(volts), .ext_level(ext_level), .cmp_inm_sel(cmp_inm_sel),
      .pin_out(pin_out), .pin_oe(pin_oe), .cmp_raw(cmp_raw), .pin_in(pin_in));

   // Prints the verdict and ends the run.
   task automatic complete_run();
      if (err_total == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Counts a comparison and reports a mismatch at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Waits for hready high at a rising edge, under a bound.
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            err_total++;
            $display("unexpected at %0t: bus hang", $time);
            complete_run();
         end
         @(posedge hclk);
      end
   endtask

   // One single-word transfer; read data lands in rd.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   // Reads a register and compares it.
   task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, '0);
      check(rd, exp);
   endtask

   // Analog-role mask of each mode.
   function automatic logic [5:0] amask(input logic [2:0] m);
      case (m)
         3'd3, 3'd6: amask = 6'h19;
         3'd5: amask = 6'h18;
         3'd7: amask = 6'h00;
         default: amask = 6'h1B;
      endcase
   endfunction

   // Expected comparator outputs from the voltages, mode, invert and switch bits.
   function automatic logic [1:0] result(input logic [2:0] m, input logic [1:0] inv, input logic input_switch_select);
      logic [1:0] en;
      logic [1:0] sel;
      logic [1:0] r;
      en  = {m != 3'd0 && m != 3'd7, m != 3'd0 && m != 3'd7 && m != 3'd5};
      sel = {input_switch_select && m == 3'd2, input_switch_select && (m == 3'd1 || m == 3'd2)};
      for (int k = 0; k < 2; k++) begin
         r[k] = en[k] && (volts[24*k +: 8] > (sel[k] ? volts[24*k+16 +: 8] : volts[24*k+8 +: 8]));
      end
      return r ^ inv;
   endfunction

   // Main sequence: reset, mode sweep, change detection, interrupt gating.
   initial begin
      logic [2:0] m;
      logic [1:0] inv;
      logic [1:0] r;
      logic       input_switch_select;
      logic [5:0] dig;
      void'($urandom(41));
      ext_level <= 6'h3F;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Reset state of configuration and pins.
      expect_reg(OFS_CONFIG, '0);
      check({hresp, pin_oe, cmp_enable, irq}, 10'h0);
      check(pin_ain, 6'h1B);
      expect_reg(OFS_PORT, 32'h24);
      expect_reg(OFS_DIR, 32'h3F);
      bus(1'b1, 8'h18, 32'hFFFF_FFFF);
      expect_reg(8'h18, '0);
      // Every mode with random polarity, switch and levels.
      for (int i = 0; i < 32; i++) begin
         m = i[4:2];
         inv = 2'($urandom);
         input_switch_select = 1'($urandom);
         volts <= 48'({$urandom, $urandom});
         ext_level <= 6'($urandom);
         bus(1'b1, OFS_CONFIG, {26'h0, inv, input_switch_select, m});
         // Output pins set to drive in the routing mode.
         bus(1'b1, OFS_DIR, (m == 3'd6) ? 32'h1B : 32'h3F);
         repeat (8) @(posedge hclk);
         r = result(m, inv, input_switch_select);
         dig = (m == 3'd6) ? {r[1], 2'b00, r[0], 2'b00} : 6'h00;
         expect_reg(OFS_CONFIG, {24'h0, r, inv, input_switch_select, m});
         check(pin_ain, amask(m));
         check(pin_out, dig);
         check(pin_oe, (m == 3'd6) ? 6'h24 : 6'h00);
         expect_reg(OFS_PORT, {26'h0, (dig | (ext_level & ~((m == 3'd6) ? 6'h24 : 6'h00))) & ~amask(m)});
      end
      // Settle after enabling, then clear mismatch and flags.
      volts <= 48'h0014_0A00_140A;
      bus(1'b1, OFS_CONFIG, 32'h4);
      // About one microsecond of bias settling at 25 ns per cycle.
      repeat (40) @(posedge hclk);
      bus(1'b0, OFS_CONFIG, '0);
      bus(1'b1, OFS_FLAG, '0);
      expect_reg(OFS_FLAG, '0);
      // Change on one comparator sets only its flag.
      volts[7:0] <= 8'h1E;
      repeat (8) @(posedge hclk);
      expect_reg(OFS_FLAG, 32'h1);
      check(irq, 1'b0);
      bus(1'b1, OFS_FLAG, '0);
      expect_reg(OFS_FLAG, 32'h1);
      bus(1'b0, OFS_CONFIG, '0);
      bus(1'b1, OFS_FLAG, '0);
      expect_reg(OFS_FLAG, '0);
      volts[31:24] <= 8'h1E;
      repeat (8) @(posedge hclk);
      expect_reg(OFS_FLAG, 32'h2);
      bus(1'b1, OFS_CONFIG, 32'h4);
      bus(1'b1, OFS_FLAG, '0);
      expect_reg(OFS_FLAG, '0);
      volts[7:0] <= 8'h0A;
      repeat (8) @(posedge hclk);
      expect_reg(OFS_FLAG, 32'h1);
      volts[7:0] <= 8'h1E;
      repeat (8) @(posedge hclk);
      bus(1'b1, OFS_FLAG, '0);
      expect_reg(OFS_FLAG, '0);
      // Software-set flag, request only with all enables.
      for (int e = 0; e < 8; e++) begin
         bus(1'b1, OFS_ENABLE, {31'h0, e[0]});
         bus(1'b1, OFS_IRQCTL, {24'h0, e[2:1], 6'h00});
         bus(1'b1, OFS_FLAG, 32'h1);
         repeat (3) @(posedge hclk);
         check(irq, e == 7);
         expect_reg(OFS_FLAG, 32'h1);
         bus(1'b1, OFS_FLAG, '0);
      end
      bus(1'b1, OFS_IRQCTL, '0);
      bus(1'b1, OFS_CONFIG, 32'h7);
      repeat (8) @(posedge hclk);
      check(irq, 1'b0);
      expect_reg(OFS_FLAG, 32'h3);
      // Reset in mid-run returns the reset state.
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      expect_reg(OFS_CONFIG, '0);
      expect_reg(OFS_FLAG, '0);
      check(pin_ain, 6'h1B);
      check({hresp, pin_oe, cmp_enable, irq}, 10'h0);
      complete_run();
   end
endmodule
